// ---- src/doc_ctrl.sv ----
// Purpose: output-state and action control of an 18-bit voltage dac
// Assumes: pclk 25 MHz, presetn async active low, pins asynchronous
// Notes: one flop-struct, registered copy; action bits self-clear
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
// Notes on behaviour
// - writing one to load action copies pending code into converter register
// - writing one to preset action loads the stored clear code into converter
// - clear code is used in the currently selected coding, binary or twos complement
// - writing one to reset action returns all registers to power-on values
// - at power-on every register takes its default value
// - after power-on converter is tristated and output clamped to ground
// - tristate and clamp stay until host changes control bits
// - leaving tristate and clamp, output sits at midscale (code zero, twos complement) unless loaded
// - float and clamp bits select three states; both zero is normal
// - clamp bit one forces ground clamp whatever the float bit
// - float one with clamp zero leaves output high impedance
// - software action bit acts like a low pulse on its pin
// - software preset action ignored while load pin held low
// - software load action ignored while preset pin held low
module doc_ctrl (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic load_update_n,
   input wire logic restore_preset_n,
   output logic [doc_pkg::DOC_CODE_W-1:0] conv_code,
   output logic offset_binary,
   output logic output_float_ctl,
   output logic output_ground_clamp,
   output logic feedback_resistor_sel,
   output logic conv_update
);
   import doc_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      logic [1:0] ld_sync;
      logic [1:0] pr_sync;
      logic ld_prev;
      logic pr_prev;
      logic [4:0] ctrl;
      logic [17:0] pend;
      logic [17:0] clrc;
      logic [17:0] conv;
      logic upd;
      logic [31:0] rdata;
      logic err;
   } doc_state_t;

   doc_state_t s_q;
   doc_state_t s_d;

   function automatic doc_out_t out_state(input logic [4:0] c);
      if (c[DOC_CTL_CLAMP]) begin
         return DOC_OUT_CLAMP;
      end
      if (c[DOC_CTL_FLOAT]) begin
         return DOC_OUT_FLOAT;
      end
      return DOC_OUT_NORMAL;
   endfunction

   function automatic logic [17:0] merge18(input logic [17:0] old, input logic [31:0] w, input logic [3:0] be);
      logic [17:0] r;
      r = old;
      if (be[0]) begin
         r[7:0] = w[7:0];
      end
      if (be[1]) begin
         r[15:8] = w[15:8];
      end
      if (be[2]) begin
         r[17:16] = w[17:16];
      end
      return r;
   endfunction

   logic acc;
   logic wr;
   logic rd;
   logic ld_pin_low;
   logic pr_pin_low;
   logic sw_load;
   logic sw_preset;
   logic sw_reset;
   logic hw_load;
   logic hw_preset;
   doc_out_t ost;

   assign acc = psel & penable;
   assign wr = acc & pwrite;
   // read data is captured in the setup cycle, so it stands at the access edge
   assign rd = psel & ~penable & ~pwrite;
   assign ld_pin_low = ~s_q.ld_sync[1];
   assign pr_pin_low = ~s_q.pr_sync[1];
   // one-cycle pulses from the access edge only, nothing stored
   assign sw_load = wr && paddr == DOC_OFF_ACT && pstrb[0] && pwdata[DOC_ACT_LOAD] && !pr_pin_low;
   assign sw_preset = wr && paddr == DOC_OFF_ACT && pstrb[0] && pwdata[DOC_ACT_PRESET] && !ld_pin_low;
   assign sw_reset = wr && paddr == DOC_OFF_ACT && pstrb[0] && pwdata[DOC_ACT_RESET];
   // falling edges of the synchronised pins
   assign hw_load = s_q.ld_prev & ~s_q.ld_sync[1];
   assign hw_preset = s_q.pr_prev & ~s_q.pr_sync[1];
   assign ost = out_state(s_q.ctrl);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      s_d.ld_sync = {s_q.ld_sync[0], load_update_n};
      s_d.pr_sync = {s_q.pr_sync[0], restore_preset_n};
      s_d.ld_prev = s_q.ld_sync[1];
      s_d.pr_prev = s_q.pr_sync[1];
      s_d.upd = 1'b0;
      s_d.err = 1'b0;
      if (wr) begin
         unique case (paddr)
            DOC_OFF_CTRL: begin
               if (pstrb[0]) begin
                  s_d.ctrl = pwdata[4:0];
               end
            end
            DOC_OFF_PEND: begin
               s_d.pend = merge18(s_q.pend, pwdata, pstrb);
            end
            DOC_OFF_CLRC: begin
               s_d.clrc = merge18(s_q.clrc, pwdata, pstrb);
            end
            DOC_OFF_ACT: begin
            end
            default: begin
               s_d.err = 1'b1;
            end
         endcase
      end
      if (rd) begin
         unique case (paddr)
            DOC_OFF_CTRL: s_d.rdata = {27'h000_0000, s_q.ctrl};
            DOC_OFF_PEND: s_d.rdata = {14'h0000, s_q.pend};
            DOC_OFF_CLRC: s_d.rdata = {14'h0000, s_q.clrc};
            DOC_OFF_ACT: s_d.rdata = 32'h0000_0000;
            DOC_OFF_CONV: s_d.rdata = {14'h0000, s_q.conv};
            DOC_OFF_STAT: s_d.rdata = {27'h000_0000, s_q.pr_sync[1], s_q.ld_sync[1], 1'b0, ost};
            default: begin
               s_d.rdata = 32'h0000_0000;
               s_d.err = 1'b1;
            end
         endcase
      end
      // clear code taken raw; coding is applied downstream by offset_binary
      if (sw_preset || hw_preset) begin
         s_d.conv = s_q.clrc;
         s_d.upd = 1'b1;
      end else if (sw_load || hw_load) begin
         s_d.conv = s_q.pend;
         s_d.upd = 1'b1;
      end
      if (sw_reset) begin
         // same values as the async reset; pin syncs kept to avoid false edges
         s_d.ctrl = DOC_CTL_RST;
         s_d.pend = DOC_CODE_RST;
         s_d.clrc = DOC_CODE_RST;
         s_d.conv = DOC_CODE_RST;
         s_d.upd = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q.ld_sync <= 2'b11;
         s_q.pr_sync <= 2'b11;
         s_q.ld_prev <= 1'b1;
         s_q.pr_prev <= 1'b1;
         s_q.ctrl <= DOC_CTL_RST;
         s_q.pend <= DOC_CODE_RST;
         s_q.clrc <= DOC_CODE_RST;
         s_q.conv <= DOC_CODE_RST;
         s_q.upd <= 1'b0;
         s_q.rdata <= 32'h0000_0000;
         s_q.err <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign pready = 1'b1;
   assign prdata = s_q.rdata;
   assign pslverr = 1'b0;
   assign conv_code = s_q.conv;
   assign conv_update = s_q.upd;
   assign offset_binary = s_q.ctrl[DOC_CTL_OFFBIN];
   assign output_ground_clamp = (ost == DOC_OUT_CLAMP);
   assign output_float_ctl = (ost != DOC_OUT_NORMAL);
   assign feedback_resistor_sel = s_q.ctrl[DOC_CTL_FB_SEL];
endmodule

// ---- common/doc_pkg.sv ----
// Purpose: shared constants for the converter output-state control block
// Assumes: 32-bit apb, word-aligned registers
// Notes: offsets and layouts below are local choices where none are printed
package doc_pkg;
   // ****************************************
   // register offsets
   // ****************************************
   localparam logic [11:0] DOC_OFF_CTRL = 12'h000;
   localparam logic [11:0] DOC_OFF_PEND = 12'h004;
   localparam logic [11:0] DOC_OFF_CLRC = 12'h008;
   localparam logic [11:0] DOC_OFF_ACT = 12'h00C;
   localparam logic [11:0] DOC_OFF_CONV = 12'h010;
   localparam logic [11:0] DOC_OFF_STAT = 12'h014;
   // ****************************************
   // control register fields
   // ****************************************
   localparam int DOC_CTL_FB_SEL = 1;
   localparam int DOC_CTL_FLOAT = 2;
   localparam int DOC_CTL_CLAMP = 3;
   localparam int DOC_CTL_OFFBIN = 4;
   localparam logic [4:0] DOC_CTL_RST = 5'h0C;
   // ****************************************
   // action register fields, code width and code reset value
   // ****************************************
   localparam int DOC_ACT_LOAD = 0;
   localparam int DOC_ACT_PRESET = 1;
   localparam int DOC_ACT_RESET = 2;
   localparam int DOC_CODE_W = 18;
   localparam logic [17:0] DOC_CODE_RST = 18'h0_0000;
   // ****************************************
   // output states
   // ****************************************
   typedef enum logic [1:0] {
      DOC_OUT_NORMAL = 2'b00,
      DOC_OUT_FLOAT = 2'b01,
      DOC_OUT_CLAMP = 2'b11
   } doc_out_t;
endpackage

// ---- verif/doc_chk_properties.sv ----
// Purpose: port checker for doc_ctrl
// Assumes: apb writes carry pstrb bit0
// Notes: bound at foot of file
`timescale 1ns/1ns
module doc_chk
   import doc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic load_update_n,
   input wire logic restore_preset_n,
   input wire logic [doc_pkg::DOC_CODE_W-1:0] conv_code,
   input wire logic output_float_ctl,
   input wire logic output_ground_clamp,
   input wire logic feedback_resistor_sel,
   input wire logic conv_update
);
   wire logic wr = psel & penable & pwrite & pstrb[0];
   wire logic act = wr & (paddr == DOC_OFF_ACT);
   wire logic pins = load_update_n & restore_preset_n;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_clamp_float: assert property (output_ground_clamp |-> output_float_ctl)
      else $error("clamp without tristate");
   a_reset_state: assert property ($rose(presetn) |-> output_ground_clamp && output_float_ctl && conv_code == 0)
      else $error("bad state after reset");
   a_ctrl_decode: assert property (wr && paddr == DOC_OFF_CTRL |=> output_ground_clamp == $past(pwdata[3])
      && output_float_ctl == ($past(pwdata[2]) | $past(pwdata[3])) && feedback_resistor_sel == $past(pwdata[1]))
      else $error("control bits not applied");
   a_action_load: assert property (act && !pwdata[2] && pwdata[1:0] != 0 && pins |=> conv_update)
      else $error("action gave no update");
   a_soft_reset: assert property (act && pwdata[2] |=> output_ground_clamp && conv_code == 0 && !conv_update)
      else $error("soft reset not applied");
   a_update_pulse: assert property (conv_update |=> !conv_update)
      else $error("update longer than one cycle");
   a_preset_block: assert property (act && pwdata[2:0] == 3'b010 && !load_update_n |=> !conv_update)
      else $error("preset not ignored");
   a_load_block: assert property (act && pwdata[2:0] == 3'b001 && !restore_preset_n |=> !conv_update)
      else $error("load not ignored");
   c_soft_reset: cover property (act && pwdata[2]);
   c_update: cover property (conv_update);
   c_float: cover property (!output_ground_clamp && output_float_ctl);
endmodule
bind doc_ctrl doc_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .load_update_n,
   .restore_preset_n, .conv_code, .output_float_ctl, .output_ground_clamp, .feedback_resistor_sel, .conv_update);

// ---- verif/doc_host.sv ----
// Purpose: apb host model driving the control block
// Assumes: read data stands at the access edge and is taken there
// Notes: write data inverted when idle
`timescale 1ns/1ns
module doc_host
   import doc_pkg::*;
(
   input wire logic pclk,
   input wire logic pready,
   input wire logic [31:0] prdata,
   output logic psel = 0,
   output logic penable = 0,
   output logic pwrite = 0,
   output logic [11:0] paddr = 12'h000,
   output logic [31:0] pwdata = 32'h0000_0000,
   output logic [3:0] pstrb = 4'hF
);
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 0;
      penable <= 0;
      pwdata <= ~d;
      @(posedge pclk);
   endtask
   task set_mode(input logic fb, input logic bin);
      logic [31:0] r;
      xfer(1, DOC_OFF_CTRL, {27'h0, bin, 2'b00, fb, 1'b0}, r);
   endtask
endmodule

// ---- verif/tb_doc_ctrl.sv ----
// Purpose: directed test of doc_ctrl
// Assumes: pin sync settles within 8 cycles
// Notes: uses doc_host for bus cycles
`timescale 1ns/1ns
module tb_doc_ctrl;
   import doc_pkg::*;
   logic pclk = 0, presetn = 0, load_update_n = 1, restore_preset_n = 1;
   logic psel, penable, pwrite, pready, pslverr, offset_binary, output_float_ctl, output_ground_clamp;
   logic feedback_resistor_sel, conv_update;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] pstrb;
   logic [17:0] conv_code;
   int err_count = 0, compares = 0;
   wire logic [31:0] st = {28'h0, feedback_resistor_sel, offset_binary, output_float_ctl, output_ground_clamp};
   doc_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .load_update_n, .restore_preset_n, .conv_code, .offset_binary, .output_float_ctl, .output_ground_clamp,
      .feedback_resistor_sel, .conv_update);
   doc_host h (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
   always #20 pclk = ~pclk;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task complete_run;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      h.xfer(1, a, d, r);
   endtask
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1;
      h.xfer(0, DOC_OFF_STAT, 0, r);
      chk(r, 32'h0000_001B);
      chk(st, 32'h0000_0003);
      for (int i = 0; i < 4; i++) begin
         wr(DOC_OFF_CTRL, 32'(i * 4));
         chk(st, 32'(i == 0 ? 0 : i == 1 ? 2 : 3));
      end
      h.set_mode(1, 1);
      chk(st, 32'h0000_000C);
      chk({14'h0, conv_code}, 32'h0000_0000);
      wr(DOC_OFF_PEND, 32'h0003_FFFF);
      wr(DOC_OFF_CLRC, 32'h0001_2345);
      wr(DOC_OFF_ACT, 32'h0000_0001);
      chk({14'h0, conv_code}, 32'h0003_FFFF);
      wr(DOC_OFF_ACT, 32'h0000_0002);
      chk({14'h0, conv_code}, 32'h0001_2345);
      h.set_mode(0, 0);
      chk(st, 32'h0000_0000);
      restore_preset_n <= 0;
      wr(DOC_OFF_PEND, 32'h0000_0001);
      repeat (8) @(posedge pclk);
      wr(DOC_OFF_ACT, 32'h0000_0001);
      chk({14'h0, conv_code}, 32'h0001_2345);
      restore_preset_n <= 1;
      load_update_n <= 0;
      repeat (8) @(posedge pclk);
      chk({14'h0, conv_code}, 32'h0000_0001);
      wr(DOC_OFF_ACT, 32'h0000_0002);
      chk({14'h0, conv_code}, 32'h0000_0001);
      load_update_n <= 1;
      h.xfer(0, 12'h020, 0, r);
      chk(r, 32'h0000_0000);
      h.xfer(0, DOC_OFF_ACT, 0, r);
      chk(r, 32'h0000_0000);
      wr(DOC_OFF_ACT, 32'h0000_0004);
      chk(st, 32'h0000_0003);
      h.xfer(0, DOC_OFF_CTRL, 0, r);
      chk(r, 32'h0000_000C);
      complete_run;
   end
   initial begin
      repeat (2000) @(posedge pclk);
      err_count++;
      complete_run;
   end
endmodule
